// ==== inc/ssf_pkg.sv ====
// Purpose: Shared constants and types of the serial slave command front end.
// Assumes: One core clock; all serial pins are sampled in that clock's domain.
// Notes:   Opcode values, status bit positions and address sizes live only here.
package ssf_pkg;
	// Opcodes, shifted in most significant bit first.
	localparam logic [7:0] OPC_SET_WRITE_LATCH   = 8'h06;
	localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ       = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE      = 8'h01;
	localparam logic [7:0] OPC_MEM_READ          = 8'h03;
	localparam logic [7:0] OPC_MEM_WRITE         = 8'h02;
	localparam logic [7:0] OPC_SLEEP             = 8'hb9;

	localparam int unsigned BYTE_W     = 8;
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	localparam int unsigned ADDR_W     = 18;
	localparam logic [1:0]  LAST_ADDR_BYTE = 2'h2;

	// Status register layout.
	localparam int unsigned ST_PROT_EN_BIT = 7;
	localparam int unsigned ST_ONE_BIT     = 6;
	localparam int unsigned ST_BLK1_BIT    = 3;
	localparam int unsigned ST_BLK0_BIT    = 2;
	localparam int unsigned ST_WEF_BIT     = 1;
	localparam logic        WEF_RESET      = 1'b0;

	// Entry of the write-data buffer: a status flag above the data byte.
	localparam int unsigned WR_ENTRY_W = BYTE_W + 1;

	typedef enum logic [2:0] {
		SSF_CMD_NONE,
		SSF_CMD_SET_WRITE_LATCH,
		SSF_CMD_CLEAR_WRITE_LATCH,
		SSF_CMD_STATUS_READ,
		SSF_CMD_STATUS_WRITE,
		SSF_CMD_MEM_READ,
		SSF_CMD_MEM_WRITE,
		SSF_CMD_SLEEP
	} ssf_cmd_e;
endpackage

// ==== inc/ssf_stream_if.sv ====
// Purpose: Valid and ready word stream between the front end's own modules.
// Assumes: Source and sink share the core clock.
// Notes:   A word moves in every cycle where valid and ready are both high.
`timescale 1ns/1ps
interface ssf_stream_if #(
	parameter int unsigned W = 9
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/ssf_sync.sv ====
// Purpose: Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherence is implied.
// Notes:   Only the second stage is visible to the rest of the design.
`timescale 1ns/1ps
module ssf_sync #(
	parameter int unsigned      WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_nrst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1) begin : g_chk
		$error("ssf_sync needs WIDTH of at least one");
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage1 <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule // ssf_sync

// ==== rtl/ssf_buf2.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Writer honours ready; a word offered while full is not taken.
// Notes:   Full and empty follow the entry count exactly.
`timescale 1ns/1ps
module ssf_buf2 #(
	parameter int unsigned W = 9
) (
	input  wire logic  i_core_clk,
	input  wire logic  i_nrst,
	ssf_stream_if.snk  fill,
	ssf_stream_if.src  drain
);
	logic [W-1:0] mem [2];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;
	wire          push = fill.valid & fill.ready;
	wire          pop  = drain.valid & drain.ready;

	if (W < 1) begin : g_chk
		$error("ssf_buf2 needs W of at least one");
	end

	assign fill.ready  = (count != 2'h2);
	assign drain.valid = (count != 2'h0);
	assign drain.data  = mem[rd_ptr];

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
			mem[0] <= '0;
			mem[1] <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= fill.data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				count <= count + 2'h1;
			end else if (pop && !push) begin
				count <= count - 2'h1;
			end
		end
	end
endmodule // ssf_buf2

// ==== rtl/ssf_front_end.sv ====
// Purpose: Serial slave command front end of a byte-wide nonvolatile memory.
// Assumes: Serial clock well below half the core clock; the bench runs it at 80 ns.
// Notes:   Pins are oversampled by the core clock, so serial edges are seen two
//          to three core cycles late; that limits the usable serial rate.
//
// Function
// - Sample input on serial clock rises; change output only on falls.
// - Clock level at select fall picks mode: low is 0, high is 3.
// - In mode 3 the first rise after the clock toggles carries bit one.
// - First eight bits after select fall are the opcode.
// - One opcode per select cycle; decoding restarts only after a fall.
// - While deselected, ignore input and keep output tristated.
// - All bytes travel most significant bit first.
// - Three address bytes; keep the low 18 bits, drop the first six.
// - Unknown opcode: do nothing, ignore input until next select fall.
// - Decode 06h as latch set and 04h as latch clear.
// - Decode 05h status read, 01h status write, b9h sleep.
// - Decode 03h memory read and 02h memory write.
// - Write-enable latch is clear after power-up.
// - Latch-set opcode in its own cycle sets the internal latch.
// - Only the latch-set opcode sets the flag; status writes cannot.
// - Clear latch at select rise ending latch clear, status or memory write.
// - Eight-bit status register shows flag 0 after latch clear.
// - Write-enable flag sits in status bit 1, high when enabled.
// - After status-read opcode shift out the current status byte.
// - Hold low suspends work, ignores clock and select, tristates output.
`timescale 1ns/1ps
module ssf_front_end (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_nrst,
	input  wire logic                      i_cs_n,
	input  wire logic                      i_sck,
	input  wire logic                      i_si,
	input  wire logic                      i_hold_n,
	output logic                           o_so,
	output logic                           o_so_oe,
	output logic                           o_mode3,
	output ssf_pkg::ssf_cmd_e              o_cmd,
	output logic                           o_cmd_valid,
	output logic [ssf_pkg::ADDR_W-1:0]     o_addr,
	output logic                           o_addr_valid,
	output logic                           o_write_enable_flag,
	input  wire logic [ssf_pkg::BYTE_W-1:0] i_status_cfg,
	input  wire logic [ssf_pkg::BYTE_W-1:0] i_rd_data,
	output logic                           o_rd_strobe,
	output logic                           o_wr_valid,
	output logic [ssf_pkg::BYTE_W-1:0]     o_wr_data,
	output logic                           o_wr_is_status,
	input  wire logic                      i_wr_ready,
	output logic                           o_wr_room,
	output logic                           o_overrun
);
	import ssf_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_WDATA,
		ST_TX,
		ST_DONE,
		ST_IGNORE
	} ssf_state_e;

	// Synchronised pins: chip select and hold reset to their inactive high level.
	logic [3:0]  pins_s;
	wire         cs_n_s   = pins_s[3];
	wire         sck_s    = pins_s[2];
	wire         si_s     = pins_s[1];
	wire         hold_n_s = pins_s[0];

	ssf_sync #(
		.WIDTH     (4),
		.RESET_VAL (4'h9)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_async    ({i_cs_n, i_sck, i_si, i_hold_n}),
		.o_sync     (pins_s)
	);

	ssf_state_e            state;
	ssf_state_e            next_state;
	logic                  sck_d;
	logic                  cs_n_d;
	logic [2:0]            bit_cnt;
	logic [BYTE_W-1:0]     shift_in;
	ssf_cmd_e              cmd;
	logic [1:0]            addr_cnt;
	logic [ADDR_W-1:0]     addr;
	logic                  addr_valid;
	logic                  mode3;
	logic                  wef;
	logic [BYTE_W-1:0]     tx_shift;
	logic                  so;
	logic                  so_on;
	logic                  rd_strobe;
	logic                  overrun;

	// Edge detection works on the second synchroniser stage and its delayed copy.
	wire sck_rise = sck_s & ~sck_d;
	wire sck_fall = ~sck_s & sck_d;

	// The select edge is only taken while hold is high; a select change during
	// hold is seen once hold is released.
	wire cs_fall  = hold_n_s & cs_n_d & ~cs_n_s;
	wire cs_rise  = hold_n_s & ~cs_n_d & cs_n_s;
	wire active   = hold_n_s & ~cs_n_s & ~cs_n_d;

	// In mode 3 the clock is already high at selection, so the next edge seen is
	// a fall and the first rise after it is the first bit.
	wire rise_ev  = active & sck_rise;
	wire fall_ev  = active & sck_fall;

	wire [BYTE_W-1:0] next_byte = {shift_in[BYTE_W-2:0], si_s};
	wire              byte_done = rise_ev & (bit_cnt == LAST_BIT);

	// Opcode decoding of the completed first byte.
	wire ssf_cmd_e dec_cmd =
		(next_byte == OPC_SET_WRITE_LATCH)   ? SSF_CMD_SET_WRITE_LATCH :
		(next_byte == OPC_CLEAR_WRITE_LATCH) ? SSF_CMD_CLEAR_WRITE_LATCH :
		(next_byte == OPC_STATUS_READ)       ? SSF_CMD_STATUS_READ :
		(next_byte == OPC_STATUS_WRITE)      ? SSF_CMD_STATUS_WRITE :
		(next_byte == OPC_SLEEP)             ? SSF_CMD_SLEEP :
		(next_byte == OPC_MEM_READ)          ? SSF_CMD_MEM_READ :
		(next_byte == OPC_MEM_WRITE)         ? SSF_CMD_MEM_WRITE :
		SSF_CMD_NONE;

	wire opcode_done = byte_done & (state == ST_OPCODE);
	wire addr_last   = byte_done & (state == ST_ADDR) & (addr_cnt == LAST_ADDR_BYTE);

	// Status byte: fixed bits, the write-enable latch, and the protection bits
	// owned by the status unit. A status write reaches only that unit, so the
	// latch position cannot be written.
	wire [BYTE_W-1:0] status_byte = {
		i_status_cfg[ST_PROT_EN_BIT],
		1'b1,
		2'b00,
		i_status_cfg[ST_BLK1_BIT],
		i_status_cfg[ST_BLK0_BIT],
		wef,
		1'b0
	};

	// The latch is set on the latch-set opcode and cleared as a write cycle ends.
	wire wef_set = opcode_done & (dec_cmd == SSF_CMD_SET_WRITE_LATCH);
	wire wef_clr = cs_rise & ((cmd == SSF_CMD_CLEAR_WRITE_LATCH) |
		(cmd == SSF_CMD_STATUS_WRITE) | (cmd == SSF_CMD_MEM_WRITE));
	wire next_wef = wef_set ? 1'b1 : (wef_clr ? 1'b0 : wef);

	// Transmit loading: the byte to send is loaded on the rise that ends the
	// preceding byte, so the following fall already drives its first bit.
	wire tx_load      = byte_done & (next_state == ST_TX);
	wire tx_is_status = (state == ST_OPCODE) ? (dec_cmd == SSF_CMD_STATUS_READ)
	                                         : (cmd == SSF_CMD_STATUS_READ);
	wire [BYTE_W-1:0] tx_src = tx_is_status ? status_byte : i_rd_data;
	wire tx_shift_ev  = fall_ev & (state == ST_TX);

	// Write-data path through the two-entry buffer.
	ssf_stream_if #(.W(WR_ENTRY_W)) wr_fill ();
	ssf_stream_if #(.W(WR_ENTRY_W)) wr_drain ();

	wire wr_push = byte_done & (state == ST_WDATA);
	assign wr_fill.valid = wr_push;
	assign wr_fill.data  = {cmd == SSF_CMD_STATUS_WRITE, next_byte};
	assign wr_drain.ready = i_wr_ready;

	ssf_buf2 #(
		.W (WR_ENTRY_W)
	) u_wr_buf (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.fill       (wr_fill),
		.drain      (wr_drain)
	);

	// A serial master cannot be stalled; a byte arriving while the buffer is full
	// is dropped and flagged until the next selection.
	wire next_overrun = cs_fall ? 1'b0 : (overrun | (wr_push & ~wr_fill.ready));

	always_comb begin
		next_state = state;
		if (cs_fall) begin
			next_state = ST_OPCODE;
		end else if (cs_rise) begin
			next_state = ST_IDLE;
		end else if (byte_done) begin
			case (state)
				ST_OPCODE: begin
					case (dec_cmd)
						SSF_CMD_NONE:         next_state = ST_IGNORE;
						SSF_CMD_STATUS_READ:  next_state = ST_TX;
						SSF_CMD_STATUS_WRITE: next_state = ST_WDATA;
						SSF_CMD_MEM_READ:     next_state = ST_ADDR;
						SSF_CMD_MEM_WRITE:    next_state = ST_ADDR;
						default:              next_state = ST_DONE;
					endcase
				end
				ST_ADDR: begin
					if (addr_cnt == LAST_ADDR_BYTE) begin
						next_state = (cmd == SSF_CMD_MEM_READ) ? ST_TX : ST_WDATA;
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state  <= ST_IDLE;
			sck_d  <= 1'b0;
			cs_n_d <= 1'b1;
			wef    <= WEF_RESET;
			mode3  <= 1'b0;
		end else begin
			state <= next_state;
			sck_d <= sck_s;
			if (hold_n_s) begin
				cs_n_d <= cs_n_s;
			end
			wef <= next_wef;
			if (cs_fall) begin
				mode3 <= sck_s;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
		end else if (rise_ev) begin
			bit_cnt  <= bit_cnt + 3'h1;
			shift_in <= next_byte;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd <= SSF_CMD_NONE;
		end else if (cs_fall || cs_rise) begin
			cmd <= SSF_CMD_NONE;
		end else if (opcode_done) begin
			cmd <= dec_cmd;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_cnt   <= 2'h0;
			addr       <= '0;
			addr_valid <= 1'b0;
		end else if (cs_fall || cs_rise) begin
			addr_cnt   <= 2'h0;
			addr_valid <= 1'b0;
		end else if (byte_done && state == ST_ADDR) begin
			// Older bytes fall off the top, leaving the last 18 bits.
			addr       <= {addr[ADDR_W-BYTE_W-1:0], next_byte};
			addr_cnt   <= addr_cnt + 2'h1;
			addr_valid <= addr_last;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_shift  <= 8'h00;
			so        <= 1'b0;
			so_on     <= 1'b0;
			rd_strobe <= 1'b0;
		end else begin
			rd_strobe <= tx_load & ~tx_is_status;
			if (cs_fall || cs_rise) begin
				so_on <= 1'b0;
			end else if (tx_shift_ev) begin
				so_on <= 1'b1;
			end
			if (tx_load) begin
				tx_shift <= tx_src;
			end else if (tx_shift_ev) begin
				tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
			end
			if (tx_shift_ev) begin
				so <= tx_shift[BYTE_W-1];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			overrun <= 1'b0;
		end else begin
			overrun <= next_overrun;
		end
	end

	assign o_so                = so;
	// The output is driven only in a transmit phase, never while deselected,
	// held or ignoring an unknown opcode.
	assign o_so_oe             = active & so_on & (state == ST_TX);
	assign o_mode3             = mode3;
	assign o_cmd               = cmd;
	assign o_cmd_valid         = (cmd != SSF_CMD_NONE);
	assign o_addr              = addr;
	assign o_addr_valid        = addr_valid;
	assign o_write_enable_flag = wef;
	assign o_rd_strobe         = rd_strobe;
	assign o_wr_valid          = wr_drain.valid;
	assign o_wr_data           = wr_drain.data[BYTE_W-1:0];
	assign o_wr_is_status      = wr_drain.data[BYTE_W];
	assign o_wr_room           = wr_fill.ready;
	assign o_overrun           = overrun;
endmodule // ssf_front_end

// ==== sim/ssf_front_end_sva.sv ====
// Purpose: Concurrent checks on the ports of the serial front end.
// Assumes: One core clock domain; asynchronous active-low reset.
// Notes:   Pin edges reach the logic two to three core cycles late.
`timescale 1ns/1ps
module ssf_front_end_sva (
	input  wire logic               i_core_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_cs_n,
	input  wire logic               i_sck,
	input  wire logic               i_hold_n,
	input  wire logic               i_wr_ready,
	input  wire logic               o_so,
	input  wire logic               o_so_oe,
	input  wire logic               o_mode3,
	input  wire ssf_pkg::ssf_cmd_e  o_cmd,
	input  wire logic               o_addr_valid,
	input  wire logic               o_write_enable_flag,
	input  wire logic               o_rd_strobe,
	input  wire logic               o_wr_valid,
	input  wire logic [7:0]         o_wr_data,
	input  wire logic               o_wr_is_status,
	input  wire logic               o_wr_room,
	input  wire logic               o_overrun
);
	import ssf_pkg::*;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	a_desel_idle: assert property (i_cs_n [*5] |-> !o_so_oe && o_cmd == SSF_CMD_NONE)
		else $error("output or command active while deselected");
	a_so_on_fall: assert property ($changed(o_so) && o_so_oe |-> !$past(i_sck, 3))
		else $error("serial output changed without a clock fall");
	a_mode_pick: assert property ($changed(o_mode3) |-> o_mode3 == i_sck && !i_cs_n)
		else $error("mode does not follow clock level at select");
	a_flag_set: assert property ($rose(o_write_enable_flag) |->
		o_cmd == SSF_CMD_SET_WRITE_LATCH && !i_cs_n)
		else $error("write flag set by another command");
	a_flag_clear: assert property ($fell(o_write_enable_flag) |-> i_cs_n && $past(i_cs_n, 2))
		else $error("write flag cleared before select rise");
	a_oe_read: assert property (o_so_oe |->
		o_cmd == SSF_CMD_STATUS_READ || o_cmd == SSF_CMD_MEM_READ)
		else $error("output driven outside a read");
	a_addr_cmd: assert property (o_addr_valid |->
		o_cmd == SSF_CMD_MEM_READ || o_cmd == SSF_CMD_MEM_WRITE)
		else $error("address valid outside a memory command");
	a_rd_pulse: assert property (o_rd_strobe |->
		(o_cmd == SSF_CMD_MEM_READ && o_addr_valid) ##1 !o_rd_strobe)
		else $error("read strobe malformed");
	a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=>
		o_wr_valid && $stable(o_wr_data) && $stable(o_wr_is_status))
		else $error("write head changed while stalled");
	a_overrun_full: assert property ($rose(o_overrun) |-> !$past(o_wr_room))
		else $error("overrun raised with room left");
	a_hold_quiet: assert property (!i_hold_n [*4] |-> !o_so_oe)
		else $error("output driven while held");
endmodule // ssf_front_end_sva

// ==== sim/ssf_spi_master.sv ====
// Purpose: Behavioural SPI master for the serial pins of the front end.
// Assumes: 80 ns clock period; modes 0 and 3.
// Notes:   SO is sampled late in the high phase, since the core sees edges late.
`timescale 1ns/1ps
module ssf_spi_master (
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si,
	input  wire logic i_so
);
	logic mode3;

	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_si   = 1'b0;
		mode3  = 1'b0;
	end

	task automatic sel(input logic m3);
		mode3  = m3;
		o_sck  = m3;
		#100;
		o_cs_n = 1'b0;
		#80;
	endtask

	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			o_sck = 1'b0;
			o_si  = tx[i];
			#40;
			o_sck = 1'b1;
			#36;
			rx[i] = i_so;
			#4;
		end
		o_sck = mode3;
	endtask

	task automatic desel();
		#40;
		o_cs_n = 1'b1;
		o_si   = ~o_si;
		#200;
	endtask
endmodule // ssf_spi_master

// ==== sim/ssf_tb.sv ====
// Purpose: Self-checking bench of the serial slave command front end.
// Assumes: 100 MHz core clock; hold pin low in one scenario only; fixed status unit bits.
// Notes:   A small memory model steps its read byte on each read strobe.
`timescale 1ns/1ps
module testbench;
	import ssf_pkg::*;
	localparam logic [7:0] CFG   = 8'h8c;
	localparam int         LIMIT = 20000;
	localparam logic [7:0] OPS [8] = '{OPC_SET_WRITE_LATCH, OPC_CLEAR_WRITE_LATCH,
		OPC_STATUS_READ, OPC_STATUS_WRITE, OPC_MEM_READ, OPC_MEM_WRITE, OPC_SLEEP, 8'hff};
	localparam ssf_cmd_e   CMDS [8] = '{SSF_CMD_SET_WRITE_LATCH, SSF_CMD_CLEAR_WRITE_LATCH,
		SSF_CMD_STATUS_READ, SSF_CMD_STATUS_WRITE, SSF_CMD_MEM_READ, SSF_CMD_MEM_WRITE,
		SSF_CMD_SLEEP, SSF_CMD_NONE};
	logic              i_core_clk;
	logic              i_nrst;
	logic              i_cs_n;
	logic              i_sck;
	logic              i_si;
	logic              i_hold_n;
	logic              o_so;
	logic              o_so_oe;
	logic              o_mode3;
	ssf_cmd_e          o_cmd;
	logic              o_cmd_valid;
	logic [ADDR_W-1:0] o_addr;
	logic              o_addr_valid;
	logic              o_write_enable_flag;
	logic [BYTE_W-1:0] i_status_cfg;
	logic [BYTE_W-1:0] i_rd_data;
	logic              o_rd_strobe;
	logic              o_wr_valid;
	logic [BYTE_W-1:0] o_wr_data;
	logic              o_wr_is_status;
	logic              i_wr_ready;
	logic              o_wr_room;
	logic              o_overrun;
	logic              so_line;
	logic              so_last;
	logic [7:0]        rd_cnt;
	logic [7:0]        rx;
	int                miscompares = 0;
	int                tests_run = 0;
	int                cycles = 0;

	ssf_front_end u_dut (.i_core_clk, .i_nrst, .i_cs_n, .i_sck, .i_si, .i_hold_n, .o_so,
		.o_so_oe, .o_mode3, .o_cmd, .o_cmd_valid, .o_addr, .o_addr_valid, .o_write_enable_flag,
		.i_status_cfg, .i_rd_data, .o_rd_strobe, .o_wr_valid, .o_wr_data, .o_wr_is_status,
		.i_wr_ready, .o_wr_room, .o_overrun);
	ssf_spi_master u_mst (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si), .i_so(so_line));

	assign i_status_cfg = CFG;
	assign i_rd_data    = 8'h3c + rd_cnt;
	// A released output shows the inverse of its last bit, so stale data cannot pass.
	assign so_line      = o_so_oe ? o_so : ~so_last;

	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			so_last <= 1'b0;
			rd_cnt  <= 8'h00;
		end else begin
			if (o_so_oe)
				so_last <= o_so;
			if (o_rd_strobe)
				rd_cnt <= rd_cnt + 8'h01;
		end
	end

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	task automatic sb(input logic [7:0] b);
		u_mst.xfer(b, 8, rx);
	endtask

	task automatic open_cmd(input logic [7:0] op);
		u_mst.sel(1'b0);
		sb(op);
	endtask

	task automatic t_status(input logic m3, input logic w);
		u_mst.sel(m3);
		sb(OPC_STATUS_READ);
		chk("mode3", m3, o_mode3);
		sb(8'h00);
		u_mst.desel();
		chk("status", {CFG[7], 1'b1, 2'b00, CFG[3:2], w, 1'b0}, rx);
		chk("oe", 1'b0, o_so_oe);
	endtask

	task automatic t_abort_set();
		u_mst.sel(1'b0);
		u_mst.xfer(8'hff, 4, rx);
		u_mst.desel();
		u_mst.sel(1'b1);
		sb(OPC_SET_WRITE_LATCH);
		u_mst.desel();
		chk("flag", 1'b1, o_write_enable_flag);
	endtask

	task automatic t_opcodes();
		for (int k = 0; k < 8; k++) begin
			open_cmd(OPS[k]);
			cyc(2);
			chk("cmd", CMDS[k], o_cmd);
			chk("cmd_valid", CMDS[k] != SSF_CMD_NONE, o_cmd_valid);
			sb(OPC_STATUS_READ);
			chk("oe", k == 2, o_so_oe);
			u_mst.desel();
		end
	endtask

	task automatic t_writes();
		cyc(1);
		i_wr_ready = 1'b0;
		open_cmd(OPC_SET_WRITE_LATCH);
		u_mst.desel();
		open_cmd(OPC_STATUS_WRITE);
		// A zero written into the flag's position must leave the latch set.
		sb(8'h00);
		chk("flag", 1'b1, o_write_enable_flag);
		u_mst.desel();
		chk("flag", 1'b0, o_write_enable_flag);
		chk("wr_head", 10'h300, {o_wr_valid, o_wr_is_status, o_wr_data});
		open_cmd(OPC_SET_WRITE_LATCH);
		u_mst.desel();
		open_cmd(OPC_MEM_WRITE);
		sb(8'h00);
		sb(8'h01);
		sb(8'h23);
		chk("addr", 18'h00123, o_addr);
		sb(8'ha1);
		chk("room", 1'b0, o_wr_room);
		sb(8'ha2);
		chk("overrun", 1'b1, o_overrun);
		u_mst.desel();
		chk("flag", 1'b0, o_write_enable_flag);
		chk("wr_head", 10'h300, {o_wr_valid, o_wr_is_status, o_wr_data});
		cyc(1);
		i_wr_ready = 1'b1;
		cyc(1);
		chk("wr_head", 10'h2a1, {o_wr_valid, o_wr_is_status, o_wr_data});
		cyc(1);
		i_wr_ready = 1'b0;
		chk("wr_valid", 1'b0, o_wr_valid);
	endtask

	task automatic t_mread();
		open_cmd(OPC_MEM_READ);
		// Leading address bits are set on purpose to show that they are dropped.
		sb(8'hfe);
		sb(8'ha5);
		sb(8'hc3);
		chk("addr", 18'h2a5c3, o_addr);
		chk("addr_valid", 1'b1, o_addr_valid);
		sb(8'h00);
		chk("rd0", 8'h3c, rx);
		sb(8'h00);
		chk("rd1", 8'h3d, rx);
		u_mst.desel();
	endtask

	// Hold goes low only after the fall that drives the first status bit has been
	// seen, since a fall taken during hold is lost.
	task automatic t_hold();
		u_mst.sel(1'b0);
		sb(OPC_STATUS_READ);
		cyc(4);
		chk("oe", 1'b1, o_so_oe);
		i_hold_n = 1'b0;
		cyc(4);
		chk("oe_hold", 1'b0, o_so_oe);
		u_mst.xfer(8'hff, 4, rx);
		cyc(4);
		i_hold_n = 1'b1;
		cyc(4);
		sb(8'h00);
		u_mst.desel();
		chk("status_hold", {CFG[7], 1'b1, 2'b00, CFG[3:2], 1'b0, 1'b0}, rx);
	endtask

	initial begin
		i_nrst     = 1'b0;
		i_wr_ready = 1'b1;
		i_hold_n   = 1'b1;
		repeat (5) @(posedge i_core_clk);
		#1;
		i_nrst = 1'b1;
		cyc(3);
		chk("flag", WEF_RESET, o_write_enable_flag);
		chk("room", 1'b1, o_wr_room);
		t_abort_set();
		t_status(1'b1, 1'b1);
		t_opcodes();
		t_writes();
		t_mread();
		t_status(1'b0, 1'b0);
		t_hold();
		summarize();
	end
endmodule // testbench

bind ssf_front_end ssf_front_end_sva u_sva (.i_core_clk, .i_nrst, .i_cs_n, .i_sck, .i_hold_n,
	.i_wr_ready, .o_so, .o_so_oe, .o_mode3, .o_cmd, .o_addr_valid, .o_write_enable_flag,
	.o_rd_strobe, .o_wr_valid, .o_wr_data, .o_wr_is_status, .o_wr_room, .o_overrun);
